// >>> hw/csaseq_consts.svh
// constants for the current sense amplifier sequencer
// assumes a 50 MHz reference clock
`ifndef CSASEQ_CONSTS_SVH
`define CSASEQ_CONSTS_SVH
`define CSASEQ_CLK_MHZ 50
`define CSASEQ_TRIM_TIME_US 100
`define CSASEQ_TRIM_CYCLES (`CSASEQ_TRIM_TIME_US * `CSASEQ_CLK_MHZ)
`define CSASEQ_GAIN_5 2'h0
`define CSASEQ_GAIN_10 2'h1
`define CSASEQ_GAIN_20 2'h2
`define CSASEQ_GAIN_40 2'h3
`define CSASEQ_NCH 3
`endif

// >>> hw/csaseq_pkg.sv
// types for the current sense amplifier sequencer
// assumes csaseq_consts.svh is available
package csaseq_pkg;
    typedef enum logic [2:0] {
        CSASEQ_IDLE = 3'h1,
        CSASEQ_TRIM = 3'h2,
        CSASEQ_HOLD = 3'h4
    } csaseq_state_t;

    // per-channel analog switch controls
    typedef struct packed {
        logic inputs_short;
        logic load_disconnect;
        logic trim_run;
        logic trim_done;
        logic pos_to_switch_node;
        logic monitor_ref_neg;
        logic amp_enable;
        logic output_valid;
    } csaseq_chan_ctl_t;
endpackage

// >>> hw/csaseq_top.sv
// sequencer for three low-side current sense amplifiers
// assumes digital control inputs arrive asynchronously from pins
`timescale 1ns/1ps
`include "csaseq_consts.svh"

module csaseq_top
    import csaseq_pkg::*;
#(
    parameter int TRIM_CYCLES = `CSASEQ_TRIM_CYCLES
) (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic SYS_RST_IN,
    // calibration requests
    input wire logic [2:0] OFFSET_TRIM_REQUEST_IN,
    input wire logic CAL_PIN_IN,
    // configuration
    input wire logic [1:0] AMP_GAIN_IN,
    input wire logic REFERENCE_DIVIDER_SELECT_IN,
    input wire logic FET_DROP_SENSE_SELECT_IN,
    input wire logic LOWSIDE_MONITOR_REF_SELECT_IN,
    // gate drive timing
    input wire logic [2:0] LOWSIDE_ON_IN,
    input wire logic [2:0] DRIVE_WINDOW_DONE_IN,
    // analog controls
    output logic [1:0] EFFECTIVE_GAIN_OUT,
    output logic REF_BIDIRECTIONAL_OUT,
    output logic [2:0] INPUTS_SHORT_OUT,
    output logic [2:0] LOAD_DISCONNECT_OUT,
    output logic [2:0] TRIM_RUN_OUT,
    output logic [2:0] TRIM_DONE_OUT,
    output logic [2:0] POS_TO_SWITCH_NODE_OUT,
    output logic [2:0] MONITOR_REF_NEG_OUT,
    output logic [2:0] AMP_ENABLE_OUT,
    output logic [2:0] OUTPUT_VALID_OUT
);

    // the trim timer is 16 bits and needs at least two counts
    if (TRIM_CYCLES < 2 || TRIM_CYCLES > 65535) begin : g_bad_trim
        $error("TRIM_CYCLES out of range");
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // all slow control pins: 3 req, cal, 2 gain, div, fet, lsref, 3 on,
    // 3 window -> 15 bits
    localparam int NIN = 15;
    logic [NIN-1:0] raw;
    logic [NIN-1:0] s1_reg;
    logic [NIN-1:0] s2_reg;
    logic [NIN-1:0] s3_reg;
    logic [NIN-1:0] in_reg;

    assign raw = {OFFSET_TRIM_REQUEST_IN, CAL_PIN_IN, AMP_GAIN_IN,
                  REFERENCE_DIVIDER_SELECT_IN, FET_DROP_SENSE_SELECT_IN,
                  LOWSIDE_MONITOR_REF_SELECT_IN, LOWSIDE_ON_IN,
                  DRIVE_WINDOW_DONE_IN};

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change counts only once the last two stages agree
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            in_reg <= '0;
        end else begin
            for (int i = 0; i < NIN; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    in_reg[i] <= s3_reg[i];
                end
            end
        end
    end

    logic [2:0] req_bits;
    logic cal_pin;
    logic [1:0] gain_prog;
    logic div_sel;
    logic fet_sel;
    logic lowside_monitor_ref_select;
    logic [2:0] ls_on;
    logic [2:0] win_done;

    assign req_bits = in_reg[14:12];
    assign cal_pin = in_reg[11];
    assign gain_prog = in_reg[10:9];
    assign div_sel = in_reg[8];
    assign fet_sel = in_reg[7];
    assign lowside_monitor_ref_select = in_reg[6];
    assign ls_on = in_reg[5:3];
    assign win_done = in_reg[2:0];

    // ------------------------------------------------------------
    // per-channel calibration sequence
    // ------------------------------------------------------------
    logic [2:0] cal_req;
    assign cal_req = req_bits | {3{cal_pin}};

    csaseq_state_t state_reg [`CSASEQ_NCH];
    logic [15:0] timer_reg [`CSASEQ_NCH];
    logic [2:0] in_cal;
    logic [2:0] trimmed;

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            for (int c = 0; c < `CSASEQ_NCH; c++) begin
                state_reg[c] <= CSASEQ_IDLE;
                timer_reg[c] <= 16'h0000;
            end
        end else begin
            for (int c = 0; c < `CSASEQ_NCH; c++) begin
                case (state_reg[c])
                    CSASEQ_IDLE: begin
                        timer_reg[c] <= 16'h0000;
                        if (cal_req[c]) begin
                            state_reg[c] <= CSASEQ_TRIM;
                        end
                    end
                    CSASEQ_TRIM: begin
                        if (!cal_req[c]) begin
                            state_reg[c] <= CSASEQ_IDLE;
                            timer_reg[c] <= 16'h0000;
                        end else if (timer_reg[c] ==
                                     16'(TRIM_CYCLES - 1)) begin
                            state_reg[c] <= CSASEQ_HOLD;
                        end else begin
                            timer_reg[c] <= timer_reg[c] + 16'h0001;
                        end
                    end
                    CSASEQ_HOLD: begin
                        if (!cal_req[c]) begin
                            state_reg[c] <= CSASEQ_IDLE;
                            timer_reg[c] <= 16'h0000;
                        end
                    end
                    default: begin
                        state_reg[c] <= CSASEQ_IDLE;
                    end
                endcase
            end
        end
    end

    always_comb begin
        for (int c = 0; c < `CSASEQ_NCH; c++) begin
            in_cal[c] = state_reg[c] != CSASEQ_IDLE;
            trimmed[c] = state_reg[c] == CSASEQ_HOLD;
        end
    end

    // ------------------------------------------------------------
    // channel control decode
    // ------------------------------------------------------------
    function automatic csaseq_chan_ctl_t chan_ctl(
        input logic cal,
        input logic done,
        input logic fet,
        input logic lsref,
        input logic lson,
        input logic win
    );
        csaseq_chan_ctl_t r;
        r = '0;
        // calibration wins over the sense routing except monitor_ref_neg and amp_enable
        r.inputs_short = cal | (fet & !lson);
        r.load_disconnect = cal;
        r.trim_run = cal & !done;
        r.trim_done = done;
        r.pos_to_switch_node = fet & !cal;
        r.monitor_ref_neg = fet | lsref;
        r.amp_enable = !fet | (lson & win);
        r.output_valid = !cal & (!fet | (lson & win));
        return r;
    endfunction

    csaseq_chan_ctl_t ctl [`CSASEQ_NCH];
    always_comb begin
        for (int c = 0; c < `CSASEQ_NCH; c++) begin
            ctl[c] = chan_ctl(in_cal[c], trimmed[c], fet_sel, lowside_monitor_ref_select,
                              ls_on[c], win_done[c]);
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            EFFECTIVE_GAIN_OUT <= `CSASEQ_GAIN_5;
        end else if (|in_cal) begin
            EFFECTIVE_GAIN_OUT <= `CSASEQ_GAIN_40;
        end else begin
            EFFECTIVE_GAIN_OUT <= gain_prog;
        end
    end

    // divider removed means unidirectional unless a channel calibrates
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            REF_BIDIRECTIONAL_OUT <= 1'b1;
        end else if (|in_cal) begin
            REF_BIDIRECTIONAL_OUT <= 1'b1;
        end else begin
            REF_BIDIRECTIONAL_OUT <= !div_sel;
        end
    end

    // one flop per control so each analog switch sees a clean level
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            INPUTS_SHORT_OUT <= 3'h0;
        end else begin
            for (int c = 0; c < `CSASEQ_NCH; c++) begin
                INPUTS_SHORT_OUT[c] <= ctl[c].inputs_short;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            LOAD_DISCONNECT_OUT <= 3'h0;
        end else begin
            for (int c = 0; c < `CSASEQ_NCH; c++) begin
                LOAD_DISCONNECT_OUT[c] <= ctl[c].load_disconnect;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            TRIM_RUN_OUT <= 3'h0;
        end else begin
            for (int c = 0; c < `CSASEQ_NCH; c++) begin
                TRIM_RUN_OUT[c] <= ctl[c].trim_run;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            TRIM_DONE_OUT <= 3'h0;
        end else begin
            for (int c = 0; c < `CSASEQ_NCH; c++) begin
                TRIM_DONE_OUT[c] <= ctl[c].trim_done;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            POS_TO_SWITCH_NODE_OUT <= 3'h0;
        end else begin
            for (int c = 0; c < `CSASEQ_NCH; c++) begin
                POS_TO_SWITCH_NODE_OUT[c] <= ctl[c].pos_to_switch_node;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            MONITOR_REF_NEG_OUT <= 3'h0;
        end else begin
            for (int c = 0; c < `CSASEQ_NCH; c++) begin
                MONITOR_REF_NEG_OUT[c] <= ctl[c].monitor_ref_neg;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            AMP_ENABLE_OUT <= 3'h0;
        end else begin
            for (int c = 0; c < `CSASEQ_NCH; c++) begin
                AMP_ENABLE_OUT[c] <= ctl[c].amp_enable;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            OUTPUT_VALID_OUT <= 3'h0;
        end else begin
            for (int c = 0; c < `CSASEQ_NCH; c++) begin
                OUTPUT_VALID_OUT[c] <= ctl[c].output_valid;
            end
        end
    end

endmodule

// >>> tb/csaseq_ctrl_model.sv
// controller model driving the calibration requests
// assumes commands change away from the falling edge
`timescale 1ns/1ps
module csaseq_ctrl_model (
    // clock, commands and low-side on state
    input logic clk_in,
    input logic [2:0] bits_cmd_in,
    input logic pin_cmd_in,
    input logic [2:0] lowside_on_in,
    // request lines toward the device
    output logic [2:0] req_bits_out,
    output logic req_pin_out
);
    initial begin
        req_bits_out = 3'h0;
        req_pin_out = 1'b0;
    end
    // new requests wait for idle switches, drops never wait
    always @(negedge clk_in) begin
        if (lowside_on_in == 3'h0) begin
            req_bits_out <= bits_cmd_in;
            req_pin_out <= pin_cmd_in;
        end else begin
            req_bits_out <= req_bits_out & bits_cmd_in;
            req_pin_out <= req_pin_out & pin_cmd_in;
        end
    end
endmodule

// >>> tb/csaseq_properties.sv
// checker for the sense amplifier sequencer ports
// bound to csaseq_top by the testbench
`timescale 1ns/1ps
module csaseq_properties #(
    parameter int TRIM_CYCLES = 8
) (
    // clock, reset, requests and low-side on state
    input logic REF_CLK_IN,
    input logic SYS_RST_IN,
    input logic CAL_PIN_IN,
    input logic [2:0] OFFSET_TRIM_REQUEST_IN,
    input logic [2:0] LOWSIDE_ON_IN,
    // configuration
    input logic [1:0] AMP_GAIN_IN,
    input logic REFERENCE_DIVIDER_SELECT_IN,
    input logic FET_DROP_SENSE_SELECT_IN,
    input logic LOWSIDE_MONITOR_REF_SELECT_IN,
    // analog controls
    input logic [1:0] EFFECTIVE_GAIN_OUT,
    input logic REF_BIDIRECTIONAL_OUT,
    input logic [2:0] INPUTS_SHORT_OUT,
    input logic [2:0] LOAD_DISCONNECT_OUT,
    input logic [2:0] TRIM_RUN_OUT,
    input logic [2:0] TRIM_DONE_OUT,
    input logic [2:0] OUTPUT_VALID_OUT,
    input logic [2:0] POS_TO_SWITCH_NODE_OUT,
    input logic [2:0] MONITOR_REF_NEG_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    logic [15:0] run_cnt_reg;
    wire cal = CAL_PIN_IN | (|OFFSET_TRIM_REQUEST_IN);
    wire fet = FET_DROP_SENSE_SELECT_IN;
    // ----------------------------------------
    // trim length on channel 0 only
    // ----------------------------------------
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN || !TRIM_RUN_OUT[0])
            run_cnt_reg <= 16'h0;
        else
            run_cnt_reg <= run_cnt_reg + 16'h1;
    end
    a_trim_length: assert property (
        $rose(TRIM_DONE_OUT[0]) |-> run_cnt_reg == TRIM_CYCLES)
        else $error("trim length wrong");
    a_req_starts: assert property (
        $rose(OFFSET_TRIM_REQUEST_IN[0]) |-> ##[3:10] TRIM_RUN_OUT[0])
        else $error("request did not start trim");
    a_run_isolates: assert property (
        |TRIM_RUN_OUT |-> ((TRIM_RUN_OUT & ~INPUTS_SHORT_OUT) == 3'h0)
        && ((TRIM_RUN_OUT & ~LOAD_DISCONNECT_OUT) == 3'h0)
        && EFFECTIVE_GAIN_OUT == 2'h3)
        else $error("trim without isolation");
    a_hold_isolates: assert property (
        TRIM_DONE_OUT[0] |-> INPUTS_SHORT_OUT[0] && LOAD_DISCONNECT_OUT[0]
        && EFFECTIVE_GAIN_OUT == 2'h3)
        else $error("hold lost isolation");
    a_ref_forced: assert property (
        |(TRIM_RUN_OUT | TRIM_DONE_OUT) |-> REF_BIDIRECTIONAL_OUT)
        else $error("reference not bidirectional");
    a_release_gain: assert property (
        $fell(cal) |-> ##[4:10] EFFECTIVE_GAIN_OUT == AMP_GAIN_IN)
        else $error("gain not restored");
    a_fet_route: assert property (
        (fet && !cal)[*8] |-> POS_TO_SWITCH_NODE_OUT == 3'h7
        && MONITOR_REF_NEG_OUT == 3'h7)
        else $error("sense routing wrong");
    a_off_short: assert property (
        (fet && !cal && !LOWSIDE_ON_IN[0])[*8] |-> INPUTS_SHORT_OUT[0]
        && !OUTPUT_VALID_OUT[0])
        else $error("off switch not shorted");
    a_mon_ref: assert property (
        (!fet && !cal && LOWSIDE_MONITOR_REF_SELECT_IN)[*8]
        |-> MONITOR_REF_NEG_OUT == 3'h7)
        else $error("monitor reference wrong");
    a_unidir_ref: assert property (
        (REFERENCE_DIVIDER_SELECT_IN && !cal)[*8] |-> !REF_BIDIRECTIONAL_OUT)
        else $error("divider not removed");
    cover property ($rose(TRIM_DONE_OUT[0]));
    cover property ($fell(cal));
    cover property (fet && LOWSIDE_ON_IN[0] && OUTPUT_VALID_OUT[0]);
endmodule

// >>> tb/testbench.sv
// self-checking bench for the sense amplifier sequencer
// assumes short trim count of 8 cycles
`timescale 1ns/1ps
module testbench;
    localparam int TC = 8;
    logic clk = 1'b0, rst = 1'b1, pcmd = 1'b0, rq_p, div = 1'b0;
    logic fet = 1'b0, lsref = 1'b0;
    logic [1:0] gain_in = 2'h1, gain_o;
    logic [2:0] bcmd = 3'h0, rq_b, lson = 3'h0, win = 3'h0;
    logic ref_o;
    logic [2:0] short_o, disc_o, run_o, done_o, pos_o, mon_o, en_o, val_o;
    int error_cnt = 0, checks = 0;
    initial forever #10 clk = ~clk;
    csaseq_ctrl_model u_ctrl (.clk_in(clk), .bits_cmd_in(bcmd),
        .pin_cmd_in(pcmd), .lowside_on_in(lson), .req_bits_out(rq_b),
        .req_pin_out(rq_p));
    csaseq_top #(.TRIM_CYCLES(TC)) DUT (.REF_CLK_IN(clk), .SYS_RST_IN(rst),
        .OFFSET_TRIM_REQUEST_IN(rq_b), .CAL_PIN_IN(rq_p),
        .AMP_GAIN_IN(gain_in), .REFERENCE_DIVIDER_SELECT_IN(div),
        .FET_DROP_SENSE_SELECT_IN(fet), .LOWSIDE_MONITOR_REF_SELECT_IN(lsref),
        .LOWSIDE_ON_IN(lson), .DRIVE_WINDOW_DONE_IN(win),
        .EFFECTIVE_GAIN_OUT(gain_o), .REF_BIDIRECTIONAL_OUT(ref_o),
        .INPUTS_SHORT_OUT(short_o), .LOAD_DISCONNECT_OUT(disc_o),
        .TRIM_RUN_OUT(run_o), .TRIM_DONE_OUT(done_o),
        .POS_TO_SWITCH_NODE_OUT(pos_o), .MONITOR_REF_NEG_OUT(mon_o),
        .AMP_ENABLE_OUT(en_o), .OUTPUT_VALID_OUT(val_o));
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_run(input logic [2:0] m);
        int n;
        n = 0;
        while ((run_o & m) !== m) begin
            n++;
            if (n > 20) begin
                chk(4'h0, 4'h1);
                test_done();
            end
            @(negedge clk);
        end
    endtask
    // one channel request, unidirectional setup, full trim and release
    task automatic t_cal(input int ch);
        int n;
        div = 1'b1;
        bcmd[ch] = 1'b1;
        wait_run(3'h1 << ch);
        chk(short_o[ch] & disc_o[ch], 4'h1);
        chk(gain_o, 4'h3);
        chk(ref_o, 4'h1);
        n = 0;
        while (done_o[ch] !== 1'b1 && n < 40) begin
            n++;
            @(negedge clk);
        end
        chk(n[3:0], TC[3:0]);
        cyc(3);
        chk({run_o[ch], short_o[ch], disc_o[ch], done_o[ch]}, 4'h7);
        chk(gain_o, 4'h3);
        bcmd[ch] = 1'b0;
        cyc(10);
        chk(gain_o, {2'h0, gain_in});
        chk(short_o | done_o, 4'h0);
        div = 1'b0;
        cyc(1);
    endtask
    // shared pin dropped mid-trim must leave nothing finished
    task automatic t_pin_abort;
        logic [2:0] seen;
        seen = 3'h0;
        pcmd = 1'b1;
        wait_run(3'h7);
        pcmd = 1'b0;
        repeat (14) begin
            @(negedge clk);
            seen = seen | done_o;
        end
        chk(seen, 4'h0);
        chk(run_o | short_o, 4'h0);
    endtask
    task automatic t_sense;
        fet = 1'b1;
        cyc(8);
        chk(pos_o & mon_o, 4'h7);
        chk(short_o, 4'h7);
        chk(val_o, 4'h0);
        lson = 3'h7;
        cyc(8);
        chk(short_o | val_o, 4'h0);
        win = 3'h7;
        cyc(8);
        chk(en_o & val_o, 4'h7);
        lson = 3'h0;
        win = 3'h0;
        fet = 1'b0;
    endtask
    task automatic t_ref;
        lsref = 1'b1;
        cyc(8);
        chk(mon_o, 4'h7);
        lsref = 1'b0;
        div = 1'b1;
        cyc(8);
        chk(mon_o, 4'h0);
        chk(ref_o, 4'h0);
        div = 1'b0;
        cyc(8);
        chk(ref_o, 4'h1);
    endtask
    initial begin
        cyc(2);
        rst = 1'b0;
        cyc(8);
        chk(gain_o, 4'h1);
        chk(en_o, 4'h7);
        for (int c = 0; c < 3; c++)
            t_cal(c);
        gain_in = 2'h2;
        t_pin_abort();
        t_cal(0);
        t_sense();
        t_ref();
        test_done();
    end
endmodule
bind csaseq_top csaseq_properties #(.TRIM_CYCLES(TRIM_CYCLES)) u_props (
    .REF_CLK_IN(REF_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .CAL_PIN_IN(CAL_PIN_IN), .OFFSET_TRIM_REQUEST_IN(OFFSET_TRIM_REQUEST_IN),
    .LOWSIDE_ON_IN(LOWSIDE_ON_IN), .AMP_GAIN_IN(AMP_GAIN_IN),
    .REFERENCE_DIVIDER_SELECT_IN(REFERENCE_DIVIDER_SELECT_IN),
    .FET_DROP_SENSE_SELECT_IN(FET_DROP_SENSE_SELECT_IN),
    .LOWSIDE_MONITOR_REF_SELECT_IN(LOWSIDE_MONITOR_REF_SELECT_IN),
    .EFFECTIVE_GAIN_OUT(EFFECTIVE_GAIN_OUT),
    .REF_BIDIRECTIONAL_OUT(REF_BIDIRECTIONAL_OUT),
    .INPUTS_SHORT_OUT(INPUTS_SHORT_OUT),
    .LOAD_DISCONNECT_OUT(LOAD_DISCONNECT_OUT),
    .TRIM_RUN_OUT(TRIM_RUN_OUT), .TRIM_DONE_OUT(TRIM_DONE_OUT),
    .OUTPUT_VALID_OUT(OUTPUT_VALID_OUT),
    .POS_TO_SWITCH_NODE_OUT(POS_TO_SWITCH_NODE_OUT),
    .MONITOR_REF_NEG_OUT(MONITOR_REF_NEG_OUT));
